// [pecc_perf_counter.sv]
/*
 * Performance event counter control: event selectors with per-thread
 * privilege qualifiers, counter configuration with threshold, edge,
 * active-thread filtering, cascade, forced overflow and per-thread
 * interrupts, reached over AXI4-Lite.
 * Assumes event inputs arrive registered on aclk from the core pipeline.
 */
`timescale 1ns/1ps
`include "pecc_defs.svh"

// Notes on behaviour
// R1 - Thread1 user qualifier counts thread1 at levels 1-3
// R2 - Thread1 kernel qualifier counts thread1 at level 0
// R3 - Thread0 user qualifier counts thread0 at levels 1-3
// R4 - Thread0 kernel qualifier counts thread0 at level 0
// R5 - Tag enable gates micro-op tagging
// R6 - Four-bit tag value attached to tagged micro-ops
// R7 - Class picks event class, mask picks sub-events
// R8 - Thread-independent sub-events ignore which thread
// R9 - Counter increments only when enabled; reset clears
// R10 - Three-bit field selects the event selector
// R11 - Active-thread field gates none/single/both/any
// R12 - Halted or startup-waiting thread counts inactive
// R13 - Compare bit turns threshold filtering on
// R14 - Complement: at-or-below threshold, else above
// R15 - Threshold used only while compare set
// R16 - Edge counts rising transitions of comparison
// R17 - Force overflow makes every increment overflow
// R18 - Overflow interrupts thread0 when enabled
// R19 - Overflow interrupts thread1 when enabled
// R20 - Interrupt fires on next count after overflow
// R21 - Cascade starts counter after partner overflows
// R22 - Sticky overflow flag, cleared only by software
// R23 - Increment needs all qualifiers together
module pecc_perf_counter #(
    parameter int NCNT = 2,     // Counters, paired by index bit 0
    parameter int NSEL = 8,     // Event selectors
    parameter int CW   = 40     // Counter width
) (
    input  wire logic                 aclk,          // Core clock
    input  wire logic                 aresetn,       // Synchronous reset, active low
    input  wire pecc_pkg::pecc_thread_t thr0,        // Thread 0 pipeline state
    input  wire pecc_pkg::pecc_thread_t thr1,        // Thread 1 pipeline state
    input  wire pecc_pkg::pecc_shared_t shared_ev,   // Thread-independent events
    output logic [NSEL-1:0][4:0]      tag_ctl,       // Tag enable and value per selector
    output logic [NCNT-1:0]           irq_thread0,   // Interrupt to logical processor 0
    output logic [NCNT-1:0]           irq_thread1,   // Interrupt to logical processor 1
    input  wire logic [11:0]          s_axi_awaddr,  // Write address
    input  wire logic                 s_axi_awvalid, // Write address valid
    output logic                      s_axi_awready, // Write address ready
    input  wire logic [31:0]          s_axi_wdata,   // Write data
    input  wire logic [3:0]           s_axi_wstrb,   // Write byte strobes
    input  wire logic                 s_axi_wvalid,  // Write data valid
    output logic                      s_axi_wready,  // Write data ready
    output logic [1:0]                s_axi_bresp,   // Write response
    output logic                      s_axi_bvalid,  // Write response valid
    input  wire logic                 s_axi_bready,  // Write response ready
    input  wire logic [11:0]          s_axi_araddr,  // Read address
    input  wire logic                 s_axi_arvalid, // Read address valid
    output logic                      s_axi_arready, // Read address ready
    output logic [31:0]               s_axi_rdata,   // Read data
    output logic [1:0]                s_axi_rresp,   // Read response
    output logic                      s_axi_rvalid,  // Read data valid
    input  wire logic                 s_axi_rready   // Read data ready
);
    import pecc_pkg::*;

    initial
    begin
        if (NCNT < 2 || NCNT > 16 || (NCNT % 2) != 0 || NSEL < 1 || NSEL > 8 || CW < 2 || CW > 64)
            $error("pecc_perf_counter: unsupported parameters");
    end

    logic [NSEL-1:0][31:0] esc_q;
    logic [NCNT-1:0][31:0] ccc_q;
    logic [NCNT-1:0][CW-1:0] cnt_q;
    logic [NCNT-1:0]       cmp_prev_q;
    logic [NCNT-1:0]       pend_irq_q;
    logic [NCNT-1:0]       casc_arm_q;
    logic [NCNT-1:0]       inc;
    logic [NCNT-1:0]       ovf_ev;
    logic [NCNT-1:0]       cmp_now;

    // Write channel: address and data are latched independently
    logic        aw_have_q;
    logic        w_have_q;
    logic [11:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        wr_fire;
    logic [31:0] wmask;

    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
    always_comb
    begin
        for (int b = 0; b < 4; b++)
            wmask[b*8 +: 8] = {8{w_strb_q[b]}};
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_addr_q     <= 12'h000;
            w_data_q      <= `PECC_RST_WORD;
            w_strb_q      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `PECC_RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit(aw_addr_q) ? `PECC_RESP_OKAY : `PECC_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    function automatic logic wr_hit(input logic [11:0] a);
        logic ok;
        ok = 1'b0;
        if (a[1:0] == 2'b00)
        begin
            if (a >= `PECC_ESC_BASE && a < `PECC_ESC_BASE + 12'(4 * NSEL))
                ok = 1'b1;
            if (a >= `PECC_CCC_BASE && a < `PECC_CCC_BASE + 12'(4 * NCNT))
                ok = 1'b1;
            if (a >= `PECC_CNT_BASE && a < `PECC_CNT_BASE + 12'(8 * NCNT))
                ok = 1'b1;
            if (a == `PECC_STAT_OFF)
                ok = 1'b1;
        end
        return ok;
    endfunction

    // Event selector registers; tag fields reach the pipeline through one register stage
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            esc_q <= '0;
        else if (wr_fire && aw_addr_q[1:0] == 2'b00)
        begin
            for (int s = 0; s < NSEL; s++)
                if (aw_addr_q == `PECC_ESC_BASE + 12'(4 * s))
                    esc_q[s] <= (esc_q[s] & ~wmask) | (w_data_q & wmask);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            tag_ctl <= '0;
        else
            for (int s = 0; s < NSEL; s++)
                tag_ctl[s] <= esc_q[s][`PECC_ESC_TAGEN] ? // R5
                    {1'b1, esc_q[s][`PECC_ESC_TAGLO +: 4]} : 5'h00; // R6
    end

    // Qualification, filtering and counting, one counter per iteration
    logic [NCNT-1:0][4:0] ev_cnt;
    logic [NCNT-1:0]      thr_ok;
    always_comb
    begin
        for (int c = 0; c < NCNT; c++)
        begin
            logic [31:0] e;
            logic [15:0] m;
            logic        q0;
            logic        q1;
            logic        qi;
            logic [1:0]  nact;
            logic        cls_ok;
            e = esc_q[3'(ccc_q[c][`PECC_CCC_SELLO +: 3]) % NSEL]; // R10
            m = e[`PECC_ESC_MASKLO +: 16];
            cls_ok = (shared_ev.cls == e[`PECC_ESC_CLSLO +: 6]); // R7
            q0 = thr0.kernel ? e[`PECC_ESC_T0OS] : e[`PECC_ESC_T0USR]; // R3 R4
            q1 = thr1.kernel ? e[`PECC_ESC_T1OS] : e[`PECC_ESC_T1USR]; // R1 R2
            qi = (e[3:0] != 4'h0); // R8
            ev_cnt[c] = 5'h00;
            for (int b = 0; b < 16; b++)
                ev_cnt[c] = ev_cnt[c] + 5'(cls_ok && m[b] &&
                    ((thr0.sub_ev[b] && q0) || (thr1.sub_ev[b] && q1) || (shared_ev.indep[b] && qi)));
            nact = 2'(thr0.active) + 2'(thr1.active); // R12
            unique case (ccc_q[c][`PECC_CCC_ATLO +: 2]) // R11
                2'b00: thr_ok[c] = (nact == 2'd0);
                2'b01: thr_ok[c] = (nact == 2'd1);
                2'b10: thr_ok[c] = (nact == 2'd2);
                2'b11: thr_ok[c] = (nact != 2'd0);
            endcase
            cmp_now[c] = ccc_q[c][`PECC_CCC_CMPL] ? // R14 R15
                (ev_cnt[c] <= {1'b0, ccc_q[c][`PECC_CCC_THRLO +: 4]}) :
                (ev_cnt[c] >  {1'b0, ccc_q[c][`PECC_CCC_THRLO +: 4]});
            if (!ccc_q[c][`PECC_CCC_CMP]) // R13
                inc[c] = (ev_cnt[c] != 5'h00);
            else if (ccc_q[c][`PECC_CCC_EDGE]) // R16
                inc[c] = cmp_now[c] && !cmp_prev_q[c];
            else
                inc[c] = cmp_now[c];
            inc[c] = inc[c] && thr_ok[c] && ccc_q[c][`PECC_CCC_EN] && // R9 R23
                (!ccc_q[c][`PECC_CCC_CASC] || casc_arm_q[c]); // R21
            ovf_ev[c] = inc[c] && (ccc_q[c][`PECC_CCC_FOVF] || (&cnt_q[c])); // R17
        end
    end

    // Counters, sticky overflow, cascade arming and pending interrupts
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ccc_q       <= '0;
            cnt_q       <= '0;
            cmp_prev_q  <= '0;
            pend_irq_q  <= '0;
            casc_arm_q  <= '0;
            irq_thread0 <= '0;
            irq_thread1 <= '0;
        end
        else
        begin
            for (int c = 0; c < NCNT; c++)
            begin
                cmp_prev_q[c]  <= cmp_now[c] && ccc_q[c][`PECC_CCC_CMP];
                irq_thread0[c] <= 1'b0;
                irq_thread1[c] <= 1'b0;
                if (wr_fire && aw_addr_q == `PECC_CCC_BASE + 12'(4 * c))
                    ccc_q[c] <= (ccc_q[c] & ~(wmask & `PECC_CCC_WMASK)) | (w_data_q & wmask & `PECC_CCC_WMASK);
                if (wr_fire && aw_addr_q == `PECC_CCC_BASE + 12'(4 * c) && wmask[31] && !w_data_q[31])
                    ccc_q[c][`PECC_CCC_OVF] <= 1'b0;
                if (ovf_ev[c])
                    ccc_q[c][`PECC_CCC_OVF] <= 1'b1; // R22
                if (wr_fire && aw_addr_q == `PECC_CNT_BASE + 12'(8 * c))
                    cnt_q[c][31:0] <= w_data_q;
                else if (wr_fire && aw_addr_q == `PECC_CNT_BASE + 12'(8 * c + 4) && CW > 32)
                    cnt_q[c] <= CW'({w_data_q, cnt_q[c][31:0]});
                else if (inc[c])
                    cnt_q[c] <= cnt_q[c] + CW'(1);
                if (!ccc_q[c][`PECC_CCC_CASC])
                    casc_arm_q[c] <= 1'b0;
                else if (ovf_ev[c ^ 1])
                    casc_arm_q[c] <= 1'b1; // R21
                if (inc[c] && pend_irq_q[c])
                begin
                    pend_irq_q[c]  <= 1'b0; // R20
                    irq_thread0[c] <= ccc_q[c][`PECC_CCC_IRQ0]; // R18
                    irq_thread1[c] <= ccc_q[c][`PECC_CCC_IRQ1]; // R19
                end
                if (ovf_ev[c])
                    pend_irq_q[c] <= 1'b1;
            end
        end
    end

    // Read channel
    pecc_rd_state_t rd_q;
    logic [31:0] rd_word;
    logic        rd_ok;
    always_comb
    begin
        rd_word = 32'h00000000;
        rd_ok   = wr_hit(s_axi_araddr);
        for (int s = 0; s < NSEL; s++)
            if (s_axi_araddr == `PECC_ESC_BASE + 12'(4 * s))
                rd_word = esc_q[s];
        for (int c = 0; c < NCNT; c++)
        begin
            if (s_axi_araddr == `PECC_CCC_BASE + 12'(4 * c))
                rd_word = ccc_q[c];
            if (s_axi_araddr == `PECC_CNT_BASE + 12'(8 * c))
                rd_word = cnt_q[c][31:0];
            if (s_axi_araddr == `PECC_CNT_BASE + 12'(8 * c + 4))
                rd_word = 32'(64'(cnt_q[c]) >> 32);
        end
        if (s_axi_araddr == `PECC_STAT_OFF)
            rd_word = {16'h0000, 14'h0000, thr1.active, thr0.active};
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rd_q          <= PECC_RD_IDLE;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= `PECC_RST_WORD;
            s_axi_rresp   <= `PECC_RESP_OKAY;
        end
        else
        begin
            unique case (rd_q)
                PECC_RD_IDLE:
                begin
                    if (s_axi_arvalid)
                    begin
                        s_axi_arready <= 1'b1;
                        rd_q          <= PECC_RD_RESP;
                    end
                end
                PECC_RD_RESP:
                begin
                    s_axi_arready <= 1'b0;
                    s_axi_rvalid  <= 1'b1;
                    s_axi_rdata   <= rd_word;
                    s_axi_rresp   <= rd_ok ? `PECC_RESP_OKAY : `PECC_RESP_SLVERR;
                    rd_q          <= PECC_RD_HOLD;
                end
                PECC_RD_HOLD:
                begin
                    if (s_axi_rready)
                    begin
                        s_axi_rvalid <= 1'b0;
                        rd_q         <= PECC_RD_IDLE;
                    end
                end
                default:
                    rd_q <= PECC_RD_IDLE;
            endcase
        end
    end
endmodule

// [pecc_defs.svh]
/*
 * Register offsets, field positions, reset values and response codes for the
 * performance event counter control block.
 * Assumes inclusion by the design module only.
 */
`ifndef PECC_DEFS_SVH
`define PECC_DEFS_SVH

// Register byte offsets; selectors sit at 0x000 + 4*index
`define PECC_ESC_BASE       12'h000
`define PECC_CCC_BASE       12'h040
`define PECC_CNT_BASE       12'h080
`define PECC_STAT_OFF       12'h0C0

// Event selection control fields
`define PECC_ESC_T1USR      0
`define PECC_ESC_T1OS       1
`define PECC_ESC_T0USR      2
`define PECC_ESC_T0OS       3
`define PECC_ESC_TAGEN      4
`define PECC_ESC_TAGLO      5
`define PECC_ESC_MASKLO     9
`define PECC_ESC_CLSLO      25

// Counter configuration control fields
`define PECC_CCC_EN         12
`define PECC_CCC_SELLO      13
`define PECC_CCC_ATLO       16
`define PECC_CCC_CMP        18
`define PECC_CCC_CMPL       19
`define PECC_CCC_THRLO      20
`define PECC_CCC_EDGE       24
`define PECC_CCC_FOVF       25
`define PECC_CCC_IRQ0       26
`define PECC_CCC_IRQ1       27
`define PECC_CCC_CASC       30
`define PECC_CCC_OVF        31
`define PECC_CCC_WMASK      32'h4FFFF000

`define PECC_RST_WORD       32'h00000000
`define PECC_RESP_OKAY      2'h0
`define PECC_RESP_SLVERR    2'h2

`endif

// [pecc_pkg.sv]
/*
 * Types shared by the performance event counter control block.
 * Assumes pecc_defs.svh is on the include path.
 */
package pecc_pkg;
    typedef struct packed {
        logic        active;    // Not halted, not waiting for startup IPI
        logic        kernel;    // Privilege level zero
        logic [15:0] sub_ev;    // Per sub-event hit, one bit each
        logic [3:0]  tag_hit;   // Tagged micro-ops retiring
    } pecc_thread_t;

    typedef struct packed {
        logic [15:0] indep;     // Sub-events not attributable to a thread
        logic [5:0]  cls;       // Event class presented by the pipeline
    } pecc_shared_t;

    typedef struct packed {
        logic       en;
        logic [3:0] val;
    } pecc_tag_t;

    typedef enum logic [2:0] {
        PECC_RD_IDLE = 3'b001,
        PECC_RD_RESP = 3'b010,
        PECC_RD_HOLD = 3'b100
    } pecc_rd_state_t;
endpackage

// [pecc_perf_counter_monitor.sv]
/* Port checker for pecc_perf_counter: bus handshakes, tag outputs, interrupts.
   Assumes it is bound to the design and shares its clock and reset. */
`timescale 1ns/1ps
module pecc_perf_counter_monitor #(
    parameter int NCNT = 2, // Counters
    parameter int NSEL = 8  // Selectors
) (
    input wire logic                 aclk,          // Clock
    input wire logic                 aresetn,       // Reset, active low
    input wire logic [NSEL-1:0][4:0] tag_ctl,       // Tag outputs
    input wire logic [NCNT-1:0]      irq_thread0,   // Thread 0 interrupt
    input wire logic [NCNT-1:0]      irq_thread1,   // Thread 1 interrupt
    input wire logic                 s_axi_awvalid, // Write address valid
    input wire logic                 s_axi_awready, // Write address ready
    input wire logic                 s_axi_wvalid,  // Write data valid
    input wire logic                 s_axi_wready,  // Write data ready
    input wire logic                 s_axi_bvalid,  // Write response valid
    input wire logic                 s_axi_bready,  // Write response ready
    input wire logic                 s_axi_arvalid, // Read address valid
    input wire logic                 s_axi_arready, // Read address ready
    input wire logic [31:0]          s_axi_rdata,   // Read data
    input wire logic                 s_axi_rvalid,  // Read data valid
    input wire logic                 s_axi_rready   // Read data ready
);
    logic wr_seen_q;
    logic tag_ok;

    // No counter can be enabled before software has written something
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            wr_seen_q <= 1'b0;
        else if (s_axi_wvalid && s_axi_wready)
            wr_seen_q <= 1'b1;
    end

    always_comb
    begin
        tag_ok = 1'b1;
        for (int i = 0; i < NSEL; i++)
            if (!tag_ctl[i][4] && tag_ctl[i][3:0] != 4'h0)
                tag_ok = 1'b0;
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped before bready");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read data after address");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
        else $error("no write response");
    chk_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready longer than one cycle");
    chk_tag_clear: assert property (tag_ok)
        else $error("tag value without tag enable");
    chk_irq_cause: assert property ((irq_thread0 != '0 || irq_thread1 != '0) |-> wr_seen_q)
        else $error("interrupt before any configuration");
    chk_reset_quiet: assert property (disable iff (1'b0)
        !aresetn |=> irq_thread0 == '0 && irq_thread1 == '0 && !s_axi_bvalid && tag_ctl == '0)
        else $error("outputs active after reset");

    cover property (irq_thread0[0]);
    cover property (irq_thread1[0]);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property (tag_ctl != '0);
endmodule

bind pecc_perf_counter pecc_perf_counter_monitor #(.NCNT(NCNT), .NSEL(NSEL)) u_mon (.aclk, .aresetn, .tag_ctl,
    .irq_thread0, .irq_thread1, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// [pecc_core_model.sv]
/* Behavioural core pipeline: thread activity, privilege and sub-event 0.
   Assumes the bench steers run, activity, privilege and class. */
`timescale 1ns/1ps
module pecc_core_model (
    input  wire logic              aclk,     // Core clock
    input  wire logic              run,      // Emit sub-event 0
    input  wire logic [1:0]        act,      // Thread activity
    input  wire logic [1:0]        kin,      // Thread at level zero
    input  wire logic [5:0]        cls,      // Class on offer
    output pecc_pkg::pecc_thread_t thr0,     // Thread 0 state
    output pecc_pkg::pecc_thread_t thr1,     // Thread 1 state
    output pecc_pkg::pecc_shared_t shared_ev // Shared events
);
    import pecc_pkg::*;

    // A halted thread retires nothing, so it raises no sub-events
    function automatic pecc_thread_t th(input logic a, input logic k, input logic r);
        return '{active: a, kernel: k, sub_ev: {15'h0, r & a}, tag_hit: 4'h0};
    endfunction

    // One clocked driver only; the design is held in reset until these settle
    always @(posedge aclk)
    begin
        thr0 <= th(act[0], kin[0], run);
        thr1 <= th(act[1], kin[1], run);
        shared_ev <= '{indep: 16'h0, cls: cls};
    end
endmodule

// [pecc_perf_counter_tb_top.sv]
/* Self-checking bench for pecc_perf_counter with a counting model.
   Assumes pecc_core_model feeds the event ports. */
`timescale 1ns/1ps
module pecc_perf_counter_tb_top;
    import pecc_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, run = 1'b0;
    logic [1:0] act = 2'h0, kin = 2'h0, at = 2'h0;
    logic [5:0] cls = 6'h0;
    logic [3:0] q = 4'h0;
    pecc_thread_t thr0, thr1;
    pecc_shared_t shared_ev;
    logic [7:0][4:0] tag_ctl;
    logic [1:0] irq_thread0, irq_thread1, s_axi_bresp, s_axi_rresp;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int n_mismatch = 0, n_checks = 0, seed = 32'h295f, exp_cnt = 0;

    pecc_core_model u_core (.aclk, .run, .act, .kin, .cls, .thr0, .thr1, .shared_ev);
    pecc_perf_counter DUT (.aclk, .aresetn, .thr0, .thr1, .shared_ev, .tag_ctl, .irq_thread0, .irq_thread1,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    always #5 aclk = ~aclk;
    always @(posedge aclk) kin <= 2'($random(seed));

    function automatic int qual(input logic [3:0] qq, input pecc_thread_t t, input int th);
        return (t.sub_ev[0] && qq[(th == 0 ? 2 : 0) + int'(t.kernel)]) ? 1 : 0;
    endfunction

    function automatic bit at_ok(input logic [1:0] a, input int n);
        return a == 2'h0 ? n == 0 : a == 2'h1 ? n == 1 : a == 2'h2 ? n == 2 : n > 0;
    endfunction

    always @(posedge aclk)
        if (at_ok(at, int'(thr0.active) + int'(thr1.active)))
            exp_cnt += qual(q, thr0, 0) + qual(q, thr1, 1);

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        bit ad, wd;
        ad = 0;
        wd = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ad && wd))
        begin
            @(posedge aclk);
            if (s_axi_awready && !ad)
            begin
                ad = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready && !wd)
            begin
                wd = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Counting starts when both threads go idle, since the active field is none
    task automatic fire(input logic [31:0] cfg, input int th);
        int w, n;
        w = 0;
        n = 0;
        wr(12'h040, cfg, 4'hF);
        act <= 2'b00;
        while ((th ? irq_thread1[0] : irq_thread0[0]) !== 1'b1 && w < 12)
        begin
            @(posedge aclk);
            w++;
            n += th ? irq_thread0[0] : irq_thread1[0];
        end
        act <= 2'b01;
        chk("irq seen", 1, 32'(w < 12));
        chk("irq other", 0, n);
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge aclk);
        n_mismatch++;
        end_of_test();
    end

    initial
    begin
        logic [31:0] d, t, c;
        logic [1:0] r;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(12'h044, d, r);
        chk("config reset", 0, d);
        rd(12'hFFC, d, r);
        chk("unmapped resp", 2, r);
        chk("unmapped data", 0, d);
        for (int i = 0; i < 6; i++)
        begin
            t = $random(seed);
            cls <= t[14:9];
            act <= t[6:5];
            at <= t[4:3];
            q <= 4'h1 << t[8:7];
            wr({7'h0, t[2:0], 2'b00}, {1'b0, t[14:9], 16'h0001, t[19:16], t[15], 4'h1 << t[8:7]}, 4'hF);
            wr(12'h080, 32'h0, 4'hF);
            wr(12'h084, 32'h0, 4'hF);
            wr(12'h040, {14'h0, t[4:3], t[2:0], 1'b1, 12'h000}, 4'hF);
            chk("tag", t[15] ? {1'b1, t[19:16]} : 5'h0, tag_ctl[t[2:0]]);
            exp_cnt = 0;
            run <= 1'b1;
            repeat (20 + ($random(seed) & 15)) @(posedge aclk);
            run <= 1'b0;
            repeat (6) @(posedge aclk);
            rd(12'h080, d, r);
            chk("count", exp_cnt, d);
            $display("count test %0d done", i);
        end
        act <= 2'b01;
        wr(12'h000, {1'b0, cls, 25'h0}, 4'hF);
        wr(12'h080, 32'hFFFFFFFF, 4'hF);
        wr(12'h084, 32'h000000FF, 4'hF);
        fire(32'h04FC1000, 0);
        rd(12'h040, d, r);
        chk("sticky set", 32'h84FC1000, d);
        wr(12'h040, 32'h0, 4'h7);
        rd(12'h040, d, r);
        chk("sticky held", 32'h84000000, d);
        fire(32'h0AFC1000, 1);
        wr(12'h040, 32'h0, 4'hF);
        rd(12'h040, d, r);
        chk("sticky clear", 0, d);
        rd(12'h080, c, r);
        act <= 2'b00;
        repeat (10) @(posedge aclk);
        act <= 2'b01;
        rd(12'h080, d, r);
        chk("disabled count", c, d);
        $display("overflow test done");
        // Comparison is true every cycle, so only its first rising edge counts
        wr(12'h080, 32'h0, 4'hF);
        wr(12'h040, 32'h01FF1000, 4'hF);
        repeat (10) @(posedge aclk);
        rd(12'h080, d, r);
        chk("edge count", 1, d);
        wr(12'h044, 32'h40FF1000, 4'hF);
        repeat (5) @(posedge aclk);
        rd(12'h088, d, r);
        chk("cascade hold", 0, d);
        wr(12'h040, 32'h02FF1000, 4'hF);
        repeat (5) @(posedge aclk);
        rd(12'h088, d, r);
        chk("cascade run", 1, 32'(d != 0));
        $display("edge and cascade test done");
        end_of_test();
    end
endmodule
